// file: core/awc_pkg.sv
// awc_pkg: encodings, timing and state type of the add-with-carry executor
// How it works
// - destination gets destination plus source plus carry
// - source operand is never written
// - carry set adds one, clear adds none
// - C, AC, V, N, Z from byte or word result
// - indirect source: segment plus pointer, 2 bytes, 4 clocks
// - post-increment: 5 clocks, pointer plus one or two
// - 16-bit offset: 4 bytes, 6 clocks, upper first
// - 8-bit offset in byte 3: 3 bytes, 6 clocks
// - direct: 3+8 address bits, 3 bytes, 4 clocks
// - direct destination keeps sum in memory
// - register plus data8: 3 clocks, sub-code 0001 means carry
// - register plus data16: 4 bytes, 3 clocks, upper first
// - indirect destination plus data8: 3 bytes, 4 clocks
// - post-increment plus data16: 4 bytes, 5 clocks, plus two
// - offset8 plus data8: 4 bytes, 6 clocks
// - offset8 plus data16: 5 bytes, 6 clocks
// - offset16 plus data8: 5 bytes, 6 clocks
// - offset16 plus data16: 6 bytes, 6 clocks
// - direct plus data8: 4 bytes, 4 clocks
// - direct plus data16: 5 bytes, 4 clocks
package awc_pkg;
  localparam logic [3:0] AWC_GRP_ADD = 4'h0;
  localparam logic [3:0] AWC_GRP_ADD_WITH_CARRY_OP = 4'h1;
  localparam logic [3:0] AWC_GRP_IMM = 4'h9;
  localparam logic [3:0] AWC_SUB_ADD = 4'h0;
  localparam logic [3:0] AWC_SUB_ADD_WITH_CARRY_OP = 4'h1;
  localparam logic [2:0] AWC_M_REG = 3'h1;
  localparam logic [2:0] AWC_M_IND = 3'h2;
  localparam logic [2:0] AWC_M_PINC = 3'h3;
  localparam logic [2:0] AWC_M_OFF8 = 3'h4;
  localparam logic [2:0] AWC_M_OFF16 = 3'h5;
  localparam logic [2:0] AWC_M_DIR = 3'h6;
  localparam int AWC_SZ_BIT = 3;
  localparam int AWC_TO_MEM_BIT = 3;
  localparam logic [2:0] AWC_BASE_LEN = 3'h2;
  localparam logic [15:0] AWC_INC_BYTE = 16'h0001;
  localparam logic [15:0] AWC_INC_WORD = 16'h0002;
  localparam logic [4:0] AWC_DIR_PAD = 5'h00;
  localparam logic [2:0] AWC_CLK_REG = 3'h3;
  localparam logic [2:0] AWC_CLK_IND = 3'h4;
  localparam logic [2:0] AWC_CLK_PINC = 3'h5;
  localparam logic [2:0] AWC_CLK_OFF = 3'h6;
  localparam logic [2:0] AWC_CLK_DIR = 3'h4;

  typedef enum logic {AWC_IDLE = 1'b0, AWC_EXEC = 1'b1} awc_state_type;

  typedef struct packed {
    awc_state_type st;
    logic busy;
    logic [2:0] cnt;
    logic [7:0][15:0] gpr;
    logic c, ac, v, n, z;
    logic [15:0] opa, opb;
    logic wide, cin, dst_mem, pinc, rd_wait;
    logic [3:0] dreg;
    logic [2:0] preg;
    logic [23:0] addr;
    logic mem_rd, mem_wr, done, illegal;
    logic [15:0] wdata, view;
    logic [2:0] len;
  } awc_core_type;

  // extra bytes between the register byte and the immediate data
  function automatic logic [2:0] awc_ext_bytes(input logic [2:0] m);
    unique case (m)
      AWC_M_OFF8, AWC_M_DIR: return 3'h1;
      AWC_M_OFF16: return 3'h2;
      default: return 3'h0;
    endcase
  endfunction : awc_ext_bytes

  function automatic logic [2:0] awc_clocks(input logic [2:0] m);
    unique case (m)
      AWC_M_IND: return AWC_CLK_IND;
      AWC_M_PINC: return AWC_CLK_PINC;
      AWC_M_OFF8, AWC_M_OFF16: return AWC_CLK_OFF;
      AWC_M_DIR: return AWC_CLK_DIR;
      default: return AWC_CLK_REG;
    endcase
  endfunction : awc_clocks
endpackage : awc_pkg

// file: core/awc_exec.sv
// awc_exec: decode and execution of add and add-with-carry forms
`timescale 1ns/1ps
module awc_exec
  import awc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] instr_b1,
  input wire logic [7:0] instr_b2,
  input wire logic [7:0] instr_b3,
  input wire logic [7:0] instr_b4,
  input wire logic [7:0] instr_b5,
  input wire logic [7:0] instr_b6,
  input wire logic [7:0] data_segment_sel,
  input wire logic [15:0] mem_rdata,
  input wire logic [2:0] view_sel,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [2:0] instr_len,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_wide,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic flag_c,
  output logic half_carry_flag,
  output logic flag_v,
  output logic flag_n,
  output logic flag_z,
  output logic [15:0] reg_view
);

  function automatic logic [15:0] awc_rd(input logic [7:0][15:0] g, input logic [3:0] i,
                                         input logic w);
    if (w)
    begin
      return g[i[2:0]];
    end
    return {8'h00, i[0] ? g[i[3:1]][15:8] : g[i[3:1]][7:0]};
  endfunction : awc_rd

  function automatic logic [7:0][15:0] awc_wr(input logic [7:0][15:0] g,
                                              input logic [3:0] i, input logic w,
                                              input logic [15:0] d);
    logic [7:0][15:0] r;
    r = g;
    if (w)
      r[i[2:0]] = d;
    else if (i[0])
      r[i[3:1]][15:8] = d[7:0];
    else
      r[i[3:1]][7:0] = d[7:0];
    return r;
  endfunction : awc_wr

  awc_core_type s_r, s_nxt;
  logic acc, imm, ok, memop, to_mem, cin_use, commit;
  logic [2:0] mode, ext;
  logic [7:0][7:0] ib;
  logic [15:0] off, imm_val, reg_val, res;
  logic [16:0] sum_w;
  logic [8:0] sum_b;
  logic [4:0] sum_h;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the presented instruction bytes
  always_comb
  begin
    ib = {16'h0000, instr_b6, instr_b5, instr_b4, instr_b3, instr_b2, instr_b1};
    acc = s_r.st == AWC_IDLE && start;
    imm = instr_b1[7:4] == AWC_GRP_IMM;
    mode = instr_b1[2:0];
    ext = awc_ext_bytes(mode);
    memop = mode != AWC_M_REG;
    // immediate forms with a memory mode always write memory; register forms pick by bit 3
    to_mem = memop && (imm || instr_b2[AWC_TO_MEM_BIT]);
    ok = (mode >= AWC_M_REG) && (mode <= AWC_M_DIR)
         && (imm ? (instr_b2[3:0] == AWC_SUB_ADD || instr_b2[3:0] == AWC_SUB_ADD_WITH_CARRY_OP)
                 : (instr_b1[7:4] == AWC_GRP_ADD || instr_b1[7:4] == AWC_GRP_ADD_WITH_CARRY_OP));
    // offset8 taken as signed displacement
    off = (mode == AWC_M_OFF16) ? {ib[2], ib[3]} : {{8{ib[2][7]}}, ib[2]};
    // data sits after the address bytes, upper byte first
    imm_val = instr_b1[AWC_SZ_BIT] ? {ib[3'(AWC_BASE_LEN + ext)], ib[3'(AWC_BASE_LEN + ext + 3'h1)]}
                                   : {8'h00, ib[3'(AWC_BASE_LEN + ext)]};
    reg_val = awc_rd(s_r.gpr, instr_b2[7:4], instr_b1[AWC_SZ_BIT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // adder and flags, carry taken from the flag held before this instruction
  always_comb
  begin
    commit = s_r.st == AWC_EXEC && s_r.cnt == 3'h0;
    cin_use = s_r.cin & s_r.c;
    sum_w = {1'b0, s_r.opa} + {1'b0, s_r.opb} + {16'h0000, cin_use};
    sum_b = {1'b0, s_r.opa[7:0]} + {1'b0, s_r.opb[7:0]} + {8'h00, cin_use};
    sum_h = {1'b0, s_r.opa[3:0]} + {1'b0, s_r.opb[3:0]} + {4'h0, cin_use};
    res = s_r.wide ? sum_w[15:0] : {8'h00, sum_b[7:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.mem_wr = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.mem_rd = 1'b0;
    s_nxt.view = s_r.gpr[view_sel];
    unique case (s_r.st)
      AWC_IDLE:
      begin
        if (acc)
        begin
          s_nxt.illegal = !ok;
          if (ok)
          begin
            s_nxt.st = AWC_EXEC;
            s_nxt.busy = 1'b1;
            s_nxt.cnt = awc_clocks(mode) - 3'h1;
            s_nxt.len = AWC_BASE_LEN + ext
                        + (imm ? (instr_b1[AWC_SZ_BIT] ? 3'h2 : 3'h1) : 3'h0);
            s_nxt.wide = instr_b1[AWC_SZ_BIT];
            s_nxt.cin = imm ? (instr_b2[3:0] == AWC_SUB_ADD_WITH_CARRY_OP) : (instr_b1[7:4] == AWC_GRP_ADD_WITH_CARRY_OP);
            s_nxt.dst_mem = to_mem;
            s_nxt.pinc = mode == AWC_M_PINC;
            s_nxt.preg = imm ? instr_b2[6:4] : instr_b2[2:0];
            s_nxt.dreg = instr_b2[7:4];
            s_nxt.mem_rd = memop;
            if (mode == AWC_M_DIR)
              s_nxt.addr = {data_segment_sel, AWC_DIR_PAD,
                            imm ? instr_b2[6:4] : instr_b2[2:0], ib[2]};
            else
              s_nxt.addr = {data_segment_sel,
                            s_r.gpr[s_nxt.preg]
                            + ((mode == AWC_M_OFF8 || mode == AWC_M_OFF16) ? off : 16'h0000)};
            if (imm)
            begin
              s_nxt.opb = imm_val;
              s_nxt.opa = reg_val;
            end
            else if (mode == AWC_M_REG)
            begin
              s_nxt.opa = reg_val;
              s_nxt.opb = awc_rd(s_r.gpr, instr_b2[3:0], instr_b1[AWC_SZ_BIT]);
            end
            else if (to_mem)
              s_nxt.opb = reg_val;
            else
              s_nxt.opa = reg_val;
          end
        end
      end
      AWC_EXEC:
      begin
        s_nxt.cnt = s_r.cnt - 3'h1;
        s_nxt.rd_wait = s_r.mem_rd;
        // memory answers one cycle after the read strobe
        if (s_r.rd_wait)
        begin
          if (s_r.dst_mem)
            s_nxt.opa = s_r.wide ? mem_rdata : {8'h00, mem_rdata[7:0]};
          else
            s_nxt.opb = s_r.wide ? mem_rdata : {8'h00, mem_rdata[7:0]};
        end
        if (commit)
        begin
          s_nxt.st = AWC_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.wdata = res;
          s_nxt.mem_wr = s_r.dst_mem;
          if (!s_r.dst_mem)
            s_nxt.gpr = awc_wr(s_r.gpr, s_r.dreg, s_r.wide, res);
          // pointer step wins over a destination that names the same register
          if (s_r.pinc)
            s_nxt.gpr[s_r.preg] = s_r.gpr[s_r.preg]
                                  + (s_r.wide ? AWC_INC_WORD : AWC_INC_BYTE);
          s_nxt.c = s_r.wide ? sum_w[16] : sum_b[8];
          s_nxt.ac = sum_h[4];
          s_nxt.n = s_r.wide ? res[15] : res[7];
          s_nxt.z = s_r.wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
          s_nxt.v = s_r.wide ? (s_r.opa[15] == s_r.opb[15] && res[15] != s_r.opa[15])
                             : (s_r.opa[7] == s_r.opb[7] && res[7] != s_r.opa[7]);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign busy = s_r.busy;
  assign done = s_r.done;
  assign illegal = s_r.illegal;
  assign instr_len = s_r.len;
  assign mem_rd = s_r.mem_rd;
  assign mem_wr = s_r.mem_wr;
  assign mem_wide = s_r.wide;
  assign mem_addr = s_r.addr;
  assign mem_wdata = s_r.wdata;
  assign flag_c = s_r.c;
  assign half_carry_flag = s_r.ac;
  assign flag_v = s_r.v;
  assign flag_n = s_r.n;
  assign flag_z = s_r.z;
  assign reg_view = s_r.view;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_reg_clocks: assert property (acc && ok && mode == AWC_M_REG |-> ##4 s_r.done)
    else $error("register form not done after 3 clocks");
  chk_ind_clocks: assert property (acc && ok && mode == AWC_M_IND |-> ##5 s_r.done)
    else $error("indirect form not done after 4 clocks");
  chk_pinc_clocks: assert property (acc && ok && mode == AWC_M_PINC |-> ##6 s_r.done)
    else $error("post-increment form not done after 5 clocks");
  chk_off_clocks: assert property (acc && ok && (mode == AWC_M_OFF8 || mode == AWC_M_OFF16)
    |-> ##1 s_r.busy [*6] ##1 s_r.done)
    else $error("offset form not done after 6 clocks");
  chk_dir_clocks: assert property (acc && ok && mode == AWC_M_DIR |-> ##5 s_r.done)
    else $error("direct form not done after 4 clocks");
  chk_mem_read: assert property (acc && ok && memop |=> mem_rd ##1 !mem_rd)
    else $error("memory read strobe not one cycle at start");
  chk_len_word: assert property (acc && ok && imm && mode == AWC_M_REG && instr_b1[AWC_SZ_BIT]
    |=> instr_len == 3'h4)
    else $error("register plus data16 length not 4");
  chk_sum_carry: assert property (commit && s_r.wide
    |=> mem_wdata == $past(s_r.opa) + $past(s_r.opb) + {15'h0000, $past(cin_use)})
    else $error("word sum does not include carry");
  chk_zero_flag: assert property (done |-> flag_z == (mem_wide ? mem_wdata == 16'h0000
    : mem_wdata[7:0] == 8'h00))
    else $error("zero flag disagrees with result");

  cov_imm_form: cover property (acc && ok && imm);
  cov_carry_out: cover property (done && flag_c);
  cov_mem_write: cover property (mem_wr && mem_wide);
endmodule : awc_exec

// file: test/awc_exec_bench.sv
// directed scenarios for the add-with-carry executor
`timescale 1ns/1ps
module awc_exec_bench;
  import awc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [7:0] ib [6] = '{default: 8'h00};
  logic [7:0] data_segment_sel = 8'h00;
  logic [15:0] mem_rdata = 16'h0000;
  logic [2:0] view_sel = 3'h0;
  logic busy, done, illegal, mem_rd, mem_wr, mem_wide;
  logic flag_c, half_carry_flag, flag_v, flag_n, flag_z;
  logic [2:0] instr_len;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, reg_view;
  logic rd_seen;
  int errors = 0;
  int check_count = 0;

  awc_exec awc_exec_inst (.clk_sys(clk_sys), .rst(rst), .start(start), .instr_b1(ib[0]),
    .instr_b2(ib[1]), .instr_b3(ib[2]), .instr_b4(ib[3]), .instr_b5(ib[4]), .instr_b6(ib[5]),
    .data_segment_sel(data_segment_sel), .mem_rdata(mem_rdata), .view_sel(view_sel),
    .busy(busy), .done(done), .illegal(illegal), .instr_len(instr_len), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .flag_c(flag_c), .half_carry_flag(half_carry_flag), .flag_v(flag_v), .flag_n(flag_n),
    .flag_z(flag_z), .reg_view(reg_view));

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // memory data held for the whole instruction, so read latency never matters
  task automatic exec(input logic [47:0] code, input logic [7:0] seg, input logic [15:0] rd,
      input int clocks, input logic [2:0] len);
    int n;
    {ib[0], ib[1], ib[2], ib[3], ib[4], ib[5]} = code;
    data_segment_sel = seg;
    mem_rdata = rd;
    rd_seen = 1'b0;
    start = 1'b1;
    @(posedge clk_sys);
    #1;
    start = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 12)
    begin
      if (mem_rd === 1'b1)
        rd_seen = 1'b1;
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 12)
    begin
      errors++;
      tally_and_finish();
    end
    check(n, clocks + 1);
    check(32'(instr_len), 32'(len));
  endtask : exec

  task automatic flags(input logic [4:0] exp);
    check(32'({flag_c, half_carry_flag, flag_v, flag_n, flag_z}), 32'(exp));
  endtask : flags

  // reg_view lags view_sel by one cycle
  task automatic view(input logic [2:0] idx, input logic [15:0] exp);
    view_sel = idx;
    repeat (2) @(posedge clk_sys);
    #1;
    check(32'(reg_view), 32'(exp));
  endtask : view

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reg_forms();
    exec(48'h991012340000, 8'h00, 16'h0000, 3, 3'h4);
    flags(5'b00000);
    exec(48'h9920ffff0000, 8'h00, 16'h0000, 3, 3'h4);
    flags(5'b00010);
    exec(48'h992100010000, 8'h00, 16'h0000, 3, 3'h4);
    flags(5'b11001);
    check(32'(mem_wdata), 32'h0000);
    exec(48'h192100000000, 8'h00, 16'h0000, 3, 3'h2);
    flags(5'b00000);
    view(3'h2, 16'h1235);
    view(3'h1, 16'h1234);
  endtask : reg_forms

  task automatic indirect_forms();
    exec(48'h1a2900000000, 8'h05, 16'h8000, 4, 3'h2);
    check(32'({rd_seen, mem_wr, mem_wide, mem_addr}), 32'({3'b111, 24'h051234}));
    check(32'(mem_wdata), 32'h9235);
    flags(5'b00010);
    exec(48'h130100000000, 8'h05, 16'h00ff, 5, 3'h2);
    check(32'({mem_wide, mem_addr}), 32'({1'b0, 24'h051234}));
    flags(5'b00010);
    view(3'h1, 16'h1235);
    view(3'h0, 16'h00ff);
  endtask : indirect_forms

  task automatic offset_forms();
    exec(48'h1c0180000000, 8'h07, 16'h0001, 6, 3'h3);
    check(32'({mem_wide, mem_addr}), 32'({1'b1, 24'h0711b5}));
    flags(5'b01000);
    view(3'h0, 16'h0100);
    exec(48'h9d110102abcd, 8'h09, 16'h5433, 6, 3'h6);
    check(32'({mem_wr, mem_addr}), 32'({1'b1, 24'h091337}));
    check(32'(mem_wdata), 32'h0000);
    flags(5'b11001);
  endtask : offset_forms

  // carry left set by the offset case must be added in here
  task automatic direct_form();
    exec(48'h96517e100000, 8'h0a, 16'h00f0, 4, 3'h4);
    check(32'({rd_seen, mem_wr, mem_wide, mem_addr}), 32'({3'b110, 24'h0a057e}));
    check(32'(mem_wdata[7:0]), 32'h01);
    flags(5'b10000);
  endtask : direct_form

  task automatic bad_form();
    {ib[0], ib[1]} = 16'h0000;
    start = 1'b1;
    @(posedge clk_sys);
    #1;
    start = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(32'({illegal, busy}), 32'h2);
  endtask : bad_form

  // plain add must leave a set carry out of its sum
  task automatic imm_mem_forms();
    exec(48'h093100000000, 8'h00, 16'h0000, 3, 3'h2);
    check(32'({illegal, mem_wr, mem_wdata}), 32'({2'b00, 16'h1235}));
    flags(5'b00000);
    exec(48'h92110f000000, 8'h01, 16'h1234, 4, 3'h3);
    check(32'({mem_wr, mem_wide, mem_addr}), 32'({2'b10, 24'h011235}));
    check(32'(mem_wdata), 32'h0043);
    flags(5'b01000);
    exec(48'h9b2180000000, 8'h02, 16'h8001, 5, 3'h4);
    check(32'({mem_wr, mem_wide, mem_addr}), 32'({2'b11, 24'h021235}));
    check(32'(mem_wdata), 32'h0001);
    flags(5'b10100);
    view(3'h2, 16'h1237);
    exec(48'h9c30f0123400, 8'h03, 16'h0001, 6, 3'h5);
    check(32'({mem_wr, mem_wide, mem_addr}), 32'({2'b11, 24'h031225}));
    check(32'(mem_wdata), 32'h1235);
    flags(5'b00000);
    exec(48'h943110200000, 8'h04, 16'h00de, 6, 3'h4);
    check(32'({mem_wr, mem_wide, mem_addr}), 32'({2'b10, 24'h041245}));
    check(32'(mem_wdata), 32'h00fe);
    flags(5'b00010);
    exec(48'h951101000100, 8'h05, 16'h00ff, 6, 3'h5);
    check(32'({mem_wr, mem_wide, mem_addr}), 32'({2'b10, 24'h051335}));
    check(32'(mem_wdata), 32'h0000);
    flags(5'b11001);
    exec(48'h9e2140000100, 8'h06, 16'h7ffe, 4, 3'h5);
    check(32'({mem_wr, mem_wide, mem_addr}), 32'({2'b11, 24'h060240}));
    check(32'(mem_wdata), 32'h8000);
    flags(5'b01110);
    exec(48'h1e3922000000, 8'h07, 16'h0010, 4, 3'h3);
    check(32'({mem_wr, mem_wide, mem_addr}), 32'({2'b11, 24'h070122}));
    check(32'(mem_wdata), 32'h1245);
    flags(5'b00000);
    view(3'h3, 16'h1235);
  endtask : imm_mem_forms

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check(32'({busy, done, mem_rd, mem_wr, flag_c, flag_z}), 32'h0);
    view(3'h1, 16'h0000);
    reg_forms();
    indirect_forms();
    offset_forms();
    direct_form();
    bad_form();
    imm_mem_forms();
    tally_and_finish();
  end
endmodule : awc_exec_bench
